/* File: core/cpsr_regs.sv */
// Purpose: coprocessor status and identity registers, with cache test controls
// Assumes: core signals are on aclk; software reaches registers over AXI4-Lite
// Notes: cu/re bits and exception vectoring are outside this block
`timescale 1ns/100ps
`include "cpsr_defs.svh"

module cpsr_regs (
	input wire logic aclk, // 20 MHz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [3:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [3:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic exc_take, // core takes an exception, one pulse
	input wire logic exc_restore, // core executes restore-from-exception, one pulse
	input wire logic cache_access, // core data-side cache access, one pulse
	input wire logic cache_hit, // hit for that access
	input wire logic cache_store, // access is a store
	input wire logic [5:0] hw_int, // external interrupt requests, pins
	input wire logic [1:0] sw_int, // software interrupt requests
	output logic int_exception, // an unmasked interrupt is pending and the global enable (ec) is set
	output logic use_icache_as_d, // data side served by instruction array
	output logic mem_write_en, // store may go to main memory
	output logic load_from_cache, // load returns cache data even on miss
	output cpsr_pkg::cpsr_priv_e priv_mode, // current privilege
	output logic bootstrap_vector_select // exception vectors in boot space
);
	import cpsr_pkg::*;

	logic swap_caches;
	logic isolate_cache;
	logic isolated_miss_flag;
	logic parity_zero_field;
	cpsr_mask_t interrupt_mask_bits;
	logic [5:0] stack; // {ko, eo, kp, ep, kc, ec}
	logic [5:0] hw_meta;
	logic [5:0] hw_sync;
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic status_wr;
	logic [31:0] status_val;
	logic [31:0] next_status;
	logic miss_event;
	logic [7:0] pending;
	logic [31:0] strb_mask;

	// two flops before the external interrupt pins reach any logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hw_meta <= 6'h00;
			hw_sync <= 6'h00;
		end else begin
			hw_meta <= hw_int;
			hw_sync <= hw_meta;
		end
	end

	// write channel: address and data accepted in either order, then response
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CPSR_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr[3:2] == 2'h2 || aw_addr[3:2] == 2'h3)
				? `CPSR_RESP_SLVERR : `CPSR_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign status_wr = do_write && aw_addr[3:2] == 2'(`CPSR_OFF_STATUS >> 2);

	generate
		for (genvar b = 0; b < 4; b++) begin : g_strb
			assign strb_mask[8*b +: 8] = {8{w_strb[b]}};
		end
	endgenerate

	// assembled status word; reserved and parity error bits read zero
	always_comb begin
		status_val = 32'h0000_0000;
		status_val[`CPSR_BIT_BEV] = bootstrap_vector_select;
		status_val[`CPSR_BIT_TS] = 1'b1;
		status_val[`CPSR_BIT_PE] = 1'b0;
		status_val[`CPSR_BIT_CM] = isolated_miss_flag;
		status_val[`CPSR_BIT_PZ] = parity_zero_field;
		status_val[`CPSR_BIT_SWC] = swap_caches;
		status_val[`CPSR_BIT_ISC] = isolate_cache;
		status_val[`CPSR_IM_HI:`CPSR_IM_LO] = interrupt_mask_bits;
		status_val[5:0] = stack;
	end

	// only writable bits under active strobes change; the rest keep status_val
	assign next_status = (status_val & ~(strb_mask & `CPSR_WMASK))
		| (w_data & strb_mask & `CPSR_WMASK);

	// isolated miss: any data-side miss while the data array is cut off
	assign miss_event = cache_access && !cache_hit && isolate_cache;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			swap_caches <= 1'b0;
			bootstrap_vector_select <= 1'b1;
			isolate_cache <= 1'b0;
			parity_zero_field <= 1'b0;
			interrupt_mask_bits <= 8'h00;
		end else if (status_wr) begin
			swap_caches <= next_status[`CPSR_BIT_SWC];
			bootstrap_vector_select <= next_status[`CPSR_BIT_BEV];
			isolate_cache <= next_status[`CPSR_BIT_ISC];
			parity_zero_field <= next_status[`CPSR_BIT_PZ];
			interrupt_mask_bits <= next_status[`CPSR_IM_HI:`CPSR_IM_LO];
		end
	end

	// miss flag: hardware set wins over a software write of zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			isolated_miss_flag <= 1'b0;
		end else if (miss_event) begin
			isolated_miss_flag <= 1'b1;
		end else if (status_wr) begin
			isolated_miss_flag <= next_status[`CPSR_BIT_CM];
		end
	end

	// privilege/enable stack; exception beats software write, restore next
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack <= 6'h00;
		end else if (exc_take) begin
			stack <= {stack[3:0], 2'b00};
		end else if (exc_restore) begin
			stack <= {stack[5:4], stack[5:2]};
		end else if (status_wr) begin
			stack <= next_status[5:0];
		end
	end

	// read channel: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CPSR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `CPSR_RESP_OKAY;
			case (s_axi_araddr[3:2])
				2'h0: s_axi_rdata <= status_val;
				2'h1: s_axi_rdata <= `CPSR_IDENT_VAL;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `CPSR_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// interrupt gating: mask bit per source, global enable over all
	assign pending = {hw_sync, sw_int} & interrupt_mask_bits;
	assign int_exception = stack[0] && (|pending);

	assign priv_mode = stack[1] ? CPSR_USER : CPSR_KERNEL;
	assign use_icache_as_d = swap_caches;
	// stores never reach memory while isolated; loads come from cache only while isolated
	assign mem_write_en = !isolate_cache;
	assign load_from_cache = isolate_cache;

endmodule // cpsr_regs

/* File: pkg/cpsr_defs.svh */
// Purpose: offsets, field positions, write mask, identity value for the status/identity register bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: offsets are local choices; identity value is arbitrary
`ifndef CPSR_DEFS_SVH
`define CPSR_DEFS_SVH

`define CPSR_OFF_STATUS 4'h0
`define CPSR_OFF_IDENT 4'h4
`define CPSR_OFF_EVENT 4'h8
`define CPSR_OFF_INTST 4'hC

// status field positions
`define CPSR_BIT_BEV 22
`define CPSR_BIT_TS 21
`define CPSR_BIT_PE 20
`define CPSR_BIT_CM 19
`define CPSR_BIT_PZ 18
`define CPSR_BIT_SWC 17
`define CPSR_BIT_ISC 16
`define CPSR_IM_HI 15
`define CPSR_IM_LO 8

// writable bits: BOOTSTRAP_VECTOR_SELECT, CM, PZ, Swap_caches, Isolate_cache, IM, KU/IE stack; PE is in the mask but not stored (cu/re not modelled)
`define CPSR_WMASK 32'h005FFF3F

// identity value: arbitrary neutral code
`define CPSR_IDENT_VAL 32'h0000_0A5C

`define CPSR_RESP_OKAY 2'h0
`define CPSR_RESP_SLVERR 2'h2

`endif

/* File: pkg/cpsr_pkg.sv */
// Purpose: shared types for the status/identity register bank
// Assumes: nothing beyond the defs header
// Notes: privilege encoding used by the core-side ports
package cpsr_pkg;
	typedef enum logic {CPSR_KERNEL, CPSR_USER} cpsr_priv_e;
	typedef logic [7:0] cpsr_mask_t;
endpackage

/* File: tb/cpsr_regs_sva.sv */
// Purpose: port checks for cpsr_regs
// Assumes: ports only
// Notes: reset check ignores disable
`timescale 1ns/100ps
module cpsr_regs_sva (
	input wire logic aclk, // clk
	input wire logic aresetn, // rst
	input wire logic s_axi_awready, // in
	input wire logic s_axi_bvalid, // in
	input wire logic s_axi_bready, // in
	input wire logic s_axi_arready, // in
	input wire logic [31:0] s_axi_rdata, // in
	input wire logic s_axi_rvalid, // in
	input wire logic s_axi_rready, // in
	input wire logic exc_take, // in
	input wire logic int_exception, // in
	input wire logic use_icache_as_d, // in
	input wire logic mem_write_en, // in
	input wire logic load_from_cache, // in
	input wire cpsr_pkg::cpsr_priv_e priv_mode, // in
	input wire logic bootstrap_vector_select // in
);
	import cpsr_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data not held");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
	a_iso_nowrite: assert property (mem_write_en != load_from_cache)
		else $error("isolation outputs disagree");
	a_exc_kernel: assert property (exc_take |=> priv_mode == CPSR_KERNEL)
		else $error("not kernel after exception");
	a_exc_masks: assert property (exc_take |=> !int_exception)
		else $error("interrupt after exception");
	a_reset_vals: assert property (disable iff (1'b0) !aresetn |=> bootstrap_vector_select
		&& !use_icache_as_d && priv_mode == CPSR_KERNEL && !int_exception && mem_write_en)
		else $error("bad reset state");
	cover property (exc_take);
	cover property (int_exception);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule // cpsr_regs_sva
bind cpsr_regs cpsr_regs_sva u_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .exc_take,
	.int_exception, .use_icache_as_d, .mem_write_en, .load_from_cache, .priv_mode,
	.bootstrap_vector_select);

/* File: tb/test_cpsr_regs.sv */
// Purpose: self-checking bench for cpsr_regs
// Assumes: AXI4-Lite master sampled at negedge, driven at posedge
// Notes: seeded random status words plus corners
`timescale 1ns/100ps
`include "cpsr_defs.svh"
module test_cpsr_regs;
	import cpsr_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, exc_take = 0, exc_restore = 0;
	logic cache_access = 0, cache_hit = 0, cache_store = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [5:0] hw_int = 0;
	logic [1:0] sw_int = 0, s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic int_exception, use_icache_as_d, mem_write_en, load_from_cache, bootstrap_vector_select;
	cpsr_priv_e priv_mode;
	int num_errors = 0, compares = 0, seed = 41, cyc = 0;
	cpsr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .exc_take, .exc_restore, .cache_access, .cache_hit, .cache_store, .hw_int,
		.sw_int, .int_exception, .use_icache_as_d, .mem_write_en, .load_from_cache, .priv_mode,
		.bootstrap_vector_select);
	always #25 aclk = ~aclk;
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// a hung handshake would otherwise stall the run forever
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] q, output logic [1:0] r);
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			q = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge aclk);
		{exc_take, exc_restore, cache_access, cache_hit, cache_store} <= v;
		@(posedge aclk);
		{exc_take, exc_restore, cache_access, cache_hit, cache_store} <= 5'h00;
	endtask
	// pe reads zero, ts reads one, reserved bits read zero
	function automatic logic [31:0] st_exp(input logic [31:0] w);
		return (w & 32'h004FFF3F) | 32'h00200000;
	endfunction
	initial begin
		logic [31:0] d, q;
		logic [1:0] r;
		logic [5:0] s;
		cpsr_mask_t m;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CPSR_OFF_STATUS, q, r);
		chk(q, 32'h00600000, "reset status");
		wr(`CPSR_OFF_STATUS, 32'h00500000, r);
		rd(`CPSR_OFF_STATUS, q, r);
		chk(q, 32'h00600000, "boot pe write");
		wr(`CPSR_OFF_IDENT, ~`CPSR_IDENT_VAL, r);
		chk(r, `CPSR_RESP_OKAY, "ident wresp");
		rd(`CPSR_OFF_IDENT, q, r);
		chk(q, `CPSR_IDENT_VAL, "identity");
		wr(`CPSR_OFF_EVENT, 32'hFFFFFFFF, r);
		chk(r, `CPSR_RESP_SLVERR, "unmapped wresp");
		rd(`CPSR_OFF_INTST, q, r);
		chk({q[29:0], r}, `CPSR_RESP_SLVERR, "unmapped read");
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
			d = d & 32'h005BFF3F;
			wr(`CPSR_OFF_STATUS, d, r);
			rd(`CPSR_OFF_STATUS, q, r);
			chk(q, st_exp(d), "status");
			chk(use_icache_as_d, d[17], "swap");
			chk(mem_write_en, !d[16], "mem write");
			chk(load_from_cache, d[16], "cache load");
		end
		for (int j = 0; j < 3; j++) begin
			wr(`CPSR_OFF_STATUS, (j < 2) ? 32'h00010000 : 32'h0, r);
			pulse({2'b00, 1'b1, j == 1, 1'b0});
			rd(`CPSR_OFF_STATUS, q, r);
			chk(q[19], j == 0, "miss flag");
		end
		s = $random(seed);
		wr(`CPSR_OFF_STATUS, {26'h0, s}, r);
		for (int j = 0; j < 4; j++) begin
			pulse((j < 2) ? 5'h10 : 5'h08);
			s = (j < 2) ? {s[3:0], 2'b00} : {s[5:4], s[5:2]};
			rd(`CPSR_OFF_STATUS, q, r);
			chk(q[5:0], s, "stack");
			chk(priv_mode, s[1], "priv");
		end
		for (int k = 0; k < 8; k++) begin
			for (int j = 0; j < 3; j++) begin
				m = 8'h01 << k;
				if (j == 2) m = ~m;
				wr(`CPSR_OFF_STATUS, {16'h0, m, 7'h0, j != 1}, r);
				@(posedge aclk);
				{hw_int, sw_int} <= 8'h01 << k;
				repeat (3) @(posedge aclk);
				@(negedge aclk);
				chk(int_exception, j == 0, "interrupt");
			end
		end
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CPSR_OFF_STATUS, q, r);
		chk(q, 32'h00600000, "second reset");
		stop_test();
	end
endmodule // test_cpsr_regs
